// ---- port_cfg_pkg.sv ----
// Purpose: shared constants and types for the port direction/option block
// Assumes: 8-bit register port, byte addresses as printed
// Notes:   option registers start at 0x9e, above a gap after the direction registers
package port_cfg_pkg;
  localparam int          MAX_PORTS        = 4;
  localparam int          PIN_COUNT        = 8;
  localparam logic [7:0]  ADDR_PORT0_DIR   = 8'h93;
  localparam logic [7:0]  ADDR_PORT1_DIR   = 8'h94;
  localparam logic [7:0]  ADDR_PORT2_DIR   = 8'h95;
  localparam logic [7:0]  ADDR_PORT3_DIR   = 8'h96;
  localparam logic [7:0]  ADDR_PORT0_OPT   = 8'h9e;
  localparam logic [7:0]  ADDR_PORT1_OPT   = 8'h9f;
  localparam logic [7:0]  ADDR_PORT2_OPT   = 8'ha0;
  localparam logic [7:0]  ADDR_PORT3_OPT   = 8'ha1;
  localparam logic [7:0]  DIR_RESET        = 8'hff;
  localparam logic [2:0]  OPT_RESET        = 3'h0;
  localparam int          FUNC_HI          = 7;
  localparam int          FUNC_LO          = 5;
  localparam int          INOUT_BIT        = 4;
  localparam int          CAPTURE_BIT      = 3;
  localparam int          INDEX_HI         = 2;
  localparam int          INDEX_LO         = 0;
  localparam int          RSVD_PIN         = 7;
  localparam logic [2:0]  LFSEL_XTAL       = 3'h0;
  localparam logic [2:0]  LFSEL_LOW_AMP    = 3'h3;
  localparam logic [2:0]  LFSEL_DIGITAL    = 3'h4;
  localparam logic [2:0]  LFSEL_RESET      = 3'h0;
  localparam int          OPT_ENTRIES      = MAX_PORTS * PIN_COUNT * 2;
  localparam int          OPT_AW           = 6;

  // one decoded option register write
  typedef struct packed {
    logic [2:0] func;
    logic       inout_sel;
    logic       capture;
    logic [2:0] index;
  } opt_word_s;

  // per-port read selection kept after a capture write
  typedef struct packed {
    logic       inout_sel;
    logic [2:0] index;
  } opt_sel_s;
endpackage

// ---- opt_mem.sv ----
// Purpose: small storage of 3-bit pin function options
// Assumes: one write and one read port, registered read data
// Notes:   read data valid the cycle after the read address
`timescale 1ns/1ns
module opt_mem
  import port_cfg_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_ce,
  input  wire logic              i_we,
  input  wire logic [OPT_AW-1:0] i_waddr,
  input  wire logic [2:0]        i_wdata,
  input  wire logic [OPT_AW-1:0] i_raddr,
  output logic      [2:0]        o_rdata
);
  logic [2:0] mem_r [OPT_ENTRIES];
  logic [2:0] mem_nxt [OPT_ENTRIES];
  logic [2:0] rdata_nxt;

  // next state of storage and read latch
  always_comb begin
    mem_nxt   = mem_r;
    rdata_nxt = mem_r[i_raddr];
    if (i_we) begin
      mem_nxt[i_waddr] = i_wdata;
    end
  end

  // registers only; reset gives every option its default
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int k = 0; k < OPT_ENTRIES; k++) begin
        mem_r[k] <= OPT_RESET;
      end
      o_rdata <= OPT_RESET;
    end else if (i_ce) begin
      mem_r   <= mem_nxt;
      o_rdata <= rdata_nxt;
    end
  end
endmodule

// ---- port_cfg.sv ----
// Purpose: port direction registers and indexed per-pin option access
// Assumes: one clock, register port with read data one cycle later
// Notes:   option reads come from a registered memory, so the stored
//          selection is applied at the read strobe itself
`timescale 1ns/1ns
module port_cfg
  import port_cfg_pkg::*;
#(
  parameter int NUM_PORTS = 4
)(
  input  wire logic                      I_MCLK,
  input  wire logic                      I_RESETN,
  input  wire logic                      I_CE,
  input  wire logic [7:0]                I_ADDR,
  input  wire logic [7:0]                I_WDATA,
  input  wire logic                      I_WR,
  input  wire logic                      I_RD,
  input  wire logic [2:0]                I_LFSEL,
  input  wire logic                      I_PROGRAM_MODE_PIN_PIN,
  output logic      [7:0]                O_RDATA,
  output logic      [MAX_PORTS*8-1:0]    O_PIN_OE,
  output logic      [MAX_PORTS*8-1:0]    O_PIN_INPUT,
  output logic                           O_XTAL_PINS,
  output logic                           O_LOW_AMP_CLK,
  output logic                           O_DIGITAL_CLK,
  output logic                           O_FLASH_SPI_EN
);

  ////////////////////////////////////////////////////////////////////////
  // address decode helpers

  // index of a direction register, or MAX_PORTS when not one
  function automatic int dir_port(input logic [7:0] a);
    if (a == ADDR_PORT0_DIR) begin
      return 0;
    end else if (a == ADDR_PORT1_DIR) begin
      return 1;
    end else if (a == ADDR_PORT2_DIR) begin
      return 2;
    end else if (a == ADDR_PORT3_DIR) begin
      return 3;
    end else begin
      return MAX_PORTS;
    end
  endfunction

  // index of an option register, or MAX_PORTS when not one
  function automatic int opt_port(input logic [7:0] a);
    if (a == ADDR_PORT0_OPT) begin
      return 0;
    end else if (a == ADDR_PORT1_OPT) begin
      return 1;
    end else if (a == ADDR_PORT2_OPT) begin
      return 2;
    end else if (a == ADDR_PORT3_OPT) begin
      return 3;
    end else begin
      return MAX_PORTS;
    end
  endfunction

  // storage address: port, direction, pin
  function automatic logic [OPT_AW-1:0] opt_addr(input int p,
                                                 input logic io,
                                                 input logic [2:0] ix);
    logic [1:0] pp;
    pp = p[1:0];
    return {pp, io, ix};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // input pin synchroniser

  logic program_mode_pin_meta_r;
  logic program_mode_pin_sync_r;

  // program-mode pin is asynchronous; second stage is the only reader
  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      program_mode_pin_meta_r <= 1'b0;
      program_mode_pin_sync_r <= 1'b0;
    end else if (I_CE) begin
      program_mode_pin_meta_r <= I_PROGRAM_MODE_PIN_PIN;
      program_mode_pin_sync_r <= program_mode_pin_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register state

  logic [7:0] dir_r   [MAX_PORTS];
  logic [7:0] dir_nxt [MAX_PORTS];
  opt_sel_s   sel_r   [MAX_PORTS];
  opt_sel_s   sel_nxt [MAX_PORTS];
  logic       rd_opt_r;
  logic       rd_opt_nxt;
  logic [7:0] rdata_nxt;
  logic [7:0] rdata_r;
  opt_word_s  wword;
  int         wdir;
  int         wopt;
  int         rdir;
  int         ropt;
  logic              mem_we;
  logic [OPT_AW-1:0] mem_waddr;
  logic [OPT_AW-1:0] mem_raddr;
  logic [2:0]        mem_rdata;

  assign wword = opt_word_s'(I_WDATA);
  assign wdir  = dir_port(I_ADDR);
  assign wopt  = opt_port(I_ADDR);
  assign rdir  = wdir;
  assign ropt  = wopt;

  // next values of direction and selection registers
  always_comb begin
    dir_nxt    = dir_r;
    sel_nxt    = sel_r;
    rd_opt_nxt = 1'b0;
    rdata_nxt  = 8'h00;
    mem_we     = 1'b0;
    mem_waddr  = '0;
    mem_raddr  = '0;
    if (I_WR && wdir < NUM_PORTS) begin
      dir_nxt[wdir] = I_WDATA;
      if (wdir == MAX_PORTS - 1) begin
        dir_nxt[wdir][RSVD_PIN] = DIR_RESET[RSVD_PIN];
      end
    end
    if (I_WR && wopt < NUM_PORTS) begin
      if (wword.capture) begin
        // capture only: option field dropped
        sel_nxt[wopt].inout_sel = wword.inout_sel;
        sel_nxt[wopt].index     = wword.index;
      end else begin
        mem_we    = 1'b1;
        mem_waddr = opt_addr(wopt, wword.inout_sel, wword.index);
      end
    end
    if (I_RD && rdir < NUM_PORTS) begin
      rdata_nxt = dir_r[rdir];
    end
    if (I_RD && ropt < NUM_PORTS) begin
      rd_opt_nxt = 1'b1;
      mem_raddr  = opt_addr(ropt, sel_r[ropt].inout_sel,
                            sel_r[ropt].index);
    end
  end

  // register stage; unpopulated ports stay at reset forever
  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      for (int p = 0; p < MAX_PORTS; p++) begin
        dir_r[p] <= DIR_RESET;
        sel_r[p] <= '0;
      end
      rd_opt_r <= 1'b0;
      rdata_r  <= 8'h00;
    end else if (I_CE) begin
      dir_r    <= dir_nxt;
      sel_r    <= sel_nxt;
      rd_opt_r <= rd_opt_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // option storage

  opt_mem u_opt_mem (
    .i_clk   (I_MCLK),
    .i_rst_n (I_RESETN),
    .i_ce    (I_CE),
    .i_we    (mem_we),
    .i_waddr (mem_waddr),
    .i_wdata (wword.func),
    .i_raddr (mem_raddr),
    .o_rdata (mem_rdata)
  );

  // read data: option field in the top bits, lower bits read as zero
  always_comb begin
    O_RDATA = rdata_r;
    if (rd_opt_r) begin
      O_RDATA = {mem_rdata, 5'h00};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin direction outputs and clock/flash routing

  logic [MAX_PORTS*8-1:0] oe_r;
  logic [MAX_PORTS*8-1:0] in_r;
  logic [MAX_PORTS*8-1:0] oe_nxt;
  logic [MAX_PORTS*8-1:0] in_nxt;
  logic xtal_r;
  logic lamp_r;
  logic dig_r;
  logic fspi_r;

  // per-port direction mapping; missing ports stay inputs
  genvar g;
  generate
    for (g = 0; g < MAX_PORTS; g++) begin : g_port
      if (g < NUM_PORTS) begin : g_live
        assign oe_nxt[g*8 +: 8] = ~dir_r[g];
        assign in_nxt[g*8 +: 8] = dir_r[g];
      end else begin : g_dead
        assign oe_nxt[g*8 +: 8] = 8'h00;
        assign in_nxt[g*8 +: 8] = DIR_RESET;
      end
    end
  endgenerate

  // registered so every pin, clock and flash output leaves a flip-flop
  always_ff @(posedge I_MCLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      oe_r   <= '0;
      in_r   <= '1;
      xtal_r <= 1'b0;
      lamp_r <= 1'b0;
      dig_r  <= 1'b0;
      fspi_r <= 1'b0;
    end else if (I_CE) begin
      oe_r   <= oe_nxt;
      in_r   <= in_nxt;
      xtal_r <= (I_LFSEL == LFSEL_XTAL);
      lamp_r <= (I_LFSEL == LFSEL_LOW_AMP);
      dig_r  <= (I_LFSEL == LFSEL_DIGITAL);
      fspi_r <= program_mode_pin_sync_r;
    end
  end

  assign O_PIN_OE       = oe_r;
  assign O_PIN_INPUT    = in_r;
  assign O_XTAL_PINS    = xtal_r;
  assign O_LOW_AMP_CLK  = lamp_r;
  assign O_DIGITAL_CLK  = dig_r;
  assign O_FLASH_SPI_EN = fspi_r;

  ////////////////////////////////////////////////////////////////////////
  // assertions

  sequence s_dir_write;
    I_CE && I_WR && I_ADDR == ADDR_PORT0_DIR;
  endsequence

  property p_dir_oe;
    @(posedge I_MCLK) disable iff (!I_RESETN)
      s_dir_write ##1 I_CE [*1] |=> O_PIN_OE[7:0] == ~$past(I_WDATA, 2);
  endproperty
  a_dir_oe: assert property (p_dir_oe)
    else $error("direction write did not reach pin enables");

  property p_dir_reset;
    @(posedge I_MCLK) $rose(I_RESETN) |-> dir_r[0] == DIR_RESET;
  endproperty
  a_dir_reset: assert property (p_dir_reset)
    else $error("direction not all ones after reset");

  property p_rsvd;
    @(posedge I_MCLK) disable iff (!I_RESETN)
      NUM_PORTS < MAX_PORTS || dir_r[MAX_PORTS-1][RSVD_PIN];
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved direction bit changed");

  property p_capture_no_write;
    @(posedge I_MCLK) disable iff (!I_RESETN)
      I_WR && wopt < NUM_PORTS && wword.capture |-> !mem_we;
  endproperty
  a_capture_no_write: assert property (p_capture_no_write)
    else $error("capture write altered an option");

  property p_opt_read_low;
    @(posedge I_MCLK) disable iff (!I_RESETN)
      I_CE && I_RD && ropt < NUM_PORTS |=> O_RDATA[4:0] == 5'h00;
  endproperty
  a_opt_read_low: assert property (p_opt_read_low)
    else $error("option read low bits not zero");

  property p_xtal;
    @(posedge I_MCLK) disable iff (!I_RESETN)
      I_CE && I_LFSEL == LFSEL_XTAL |=> O_XTAL_PINS && !O_DIGITAL_CLK;
  endproperty
  a_xtal: assert property (p_xtal)
    else $error("crystal select not shown");

  property p_lamp;
    @(posedge I_MCLK) disable iff (!I_RESETN)
      I_CE && I_LFSEL == LFSEL_LOW_AMP |=> O_LOW_AMP_CLK && !O_XTAL_PINS;
  endproperty
  a_lamp: assert property (p_lamp)
    else $error("low amplitude select not shown");

  property p_dig;
    @(posedge I_MCLK) disable iff (!I_RESETN)
      I_CE && I_LFSEL == LFSEL_DIGITAL |=> O_DIGITAL_CLK;
  endproperty
  a_dig: assert property (p_dig)
    else $error("digital clock select not shown");

  property p_flash;
    @(posedge I_MCLK) disable iff (!I_RESETN)
      $changed(O_FLASH_SPI_EN) |-> O_FLASH_SPI_EN == $past(program_mode_pin_sync_r);
  endproperty
  a_flash: assert property (p_flash)
    else $error("flash interface not following program mode");

  // a low clock enable must freeze the pin enables and the read data
  property p_ce_hold;
    @(posedge I_MCLK) disable iff (!I_RESETN)
      !I_CE |=> $stable(O_PIN_OE) && $stable(O_RDATA);
  endproperty
  a_ce_hold: assert property (p_ce_hold)
    else $error("outputs moved while clock enable low");

  // read data stand one cycle only, then fall back to zero
  property p_rd_idle;
    @(posedge I_MCLK) disable iff (!I_RESETN)
      I_CE && !I_RD |=> O_RDATA == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data shown without a read strobe");

  // absent ports and unmapped addresses read as zero
  property p_absent_read;
    @(posedge I_MCLK) disable iff (!I_RESETN)
      I_CE && I_RD && rdir >= NUM_PORTS && ropt >= NUM_PORTS
        |=> O_RDATA == 8'h00;
  endproperty
  a_absent_read: assert property (p_absent_read)
    else $error("absent register returned data");
endmodule

// ---- ext_pads.sv ----
// Purpose: far-side model of the mode pins that feed the port block
// Assumes: pins change just after a rising edge, like a board strap
// Notes:   the bench asks for levels; the model launches them on the clock
`timescale 1ns/1ns
module ext_pads (
  input  wire logic       i_clk,
  input  wire logic       i_program_mode_pin_req,
  input  wire logic [2:0] i_lf_req,
  output logic            o_program_mode_pin_pin,
  output logic      [2:0] o_lfsel
);
  ////////////////////////////////////////////////////////////////////////
  // pins move one edge after the request, never on the sampling edge
  always @(posedge i_clk) begin
    o_program_mode_pin_pin <= i_program_mode_pin_req;
    o_lfsel    <= i_lf_req;
  end
endmodule

// ---- tb_top.sv ----
// Purpose: self-checking bench for the port direction and option block
// Assumes: register port with read data in the cycle after the strobe
// Notes:   expected option values come from a formula, not from reads
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
  fail_count++; $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top
  import port_cfg_pkg::*;
;
  logic        mclk;
  logic        resetn;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [2:0]  lfsel;
  logic        program_mode_pin_pin;
  logic        program_mode_pin_req;
  logic [2:0]  lf_req;
  logic [7:0]  rdata;
  logic [31:0] pin_oe;
  logic [31:0] pin_in;
  logic        xtal;
  logic        low_amp;
  logic        dig_clk;
  logic        flash_en;
  logic        ce;
  logic [7:0]  rdata2;
  logic [31:0] pin_oe2;
  logic [31:0] pin_in2;
  int          fail_count;
  int          check_count;

  ////////////////////////////////////////////////////////////////////////
  // clock at 25 MHz
  initial mclk = 1'b0;
  always #20 mclk = ~mclk;

  port_cfg #(.NUM_PORTS(4)) uut (
    .I_MCLK(mclk), .I_RESETN(resetn), .I_CE(ce), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .I_LFSEL(lfsel),
    .I_PROGRAM_MODE_PIN_PIN(program_mode_pin_pin), .O_RDATA(rdata), .O_PIN_OE(pin_oe),
    .O_PIN_INPUT(pin_in), .O_XTAL_PINS(xtal), .O_LOW_AMP_CLK(low_amp),
    .O_DIGITAL_CLK(dig_clk), .O_FLASH_SPI_EN(flash_en)
  );

  // a two-port build on the same bus: its absent ports must stay inert
  port_cfg #(.NUM_PORTS(2)) uut_small (
    .I_MCLK(mclk), .I_RESETN(resetn), .I_CE(ce), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .I_LFSEL(lfsel),
    .I_PROGRAM_MODE_PIN_PIN(program_mode_pin_pin), .O_RDATA(rdata2), .O_PIN_OE(pin_oe2),
    .O_PIN_INPUT(pin_in2), .O_XTAL_PINS(), .O_LOW_AMP_CLK(),
    .O_DIGITAL_CLK(), .O_FLASH_SPI_EN()
  );

  ext_pads pads (
    .i_clk(mclk), .i_program_mode_pin_req(program_mode_pin_req), .i_lf_req(lf_req),
    .o_program_mode_pin_pin(program_mode_pin_pin), .o_lfsel(lfsel)
  );

  ////////////////////////////////////////////////////////////////////////
  // one-cycle bus strobes, launched right after a rising edge
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge mclk);
    wr    <= 1'b0;
  endtask

  // data is looked at in the single cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic close_out;
    if (fail_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // option formula: differs per port, direction and pin
  function automatic logic [2:0] opt_val(int p, int io, int i);
    return 3'(i + 3 * io + p);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // watchdog: the whole sequence needs well under 1000 cycles
  initial begin
    #100000;
    fail_count++;
    close_out();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] d;
    logic [7:0] oa;
    logic [2:0] codes [5];
    fail_count  = 0;
    check_count = 0;
    addr = 8'h00; wdata = 8'h00; wr = 1'b0; rd = 1'b0;
    program_mode_pin_req = 1'b0; lf_req = 3'h1;
    ce = 1'b1;
    codes = '{3'h0, 3'h3, 3'h4, 3'h1, 3'h7};
    resetn = 1'b0;
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    // reset values of all direction registers and pin state
    for (int p = 0; p < 4; p++) begin
      rd_reg(ADDR_PORT0_DIR + 8'(p), d);
      `CHK(d, 8'hff)
    end
    `CHK(pin_in, 32'hffffffff)
    `CHK(pin_oe, 32'h00000000)
    // direction bits steer their own pin, per port
    wr_reg(ADDR_PORT0_DIR, 8'h5a);
    wr_reg(ADDR_PORT1_DIR, 8'hc3);
    rd_reg(ADDR_PORT0_DIR, d);
    `CHK(d, 8'h5a)
    `CHK(pin_oe[15:0], 16'h3ca5)
    `CHK(pin_in[15:0], 16'hc35a)
    // clock enable low freezes every register, bus writes included
    @(posedge mclk);
    ce <= 1'b0;
    wr_reg(ADDR_PORT0_DIR, 8'h00);
    ce <= 1'b1;
    rd_reg(ADDR_PORT0_DIR, d);
    `CHK(d, 8'h5a)
    `CHK(pin_oe[7:0], 8'ha5)
    // fourth port exists but its top bit is reserved
    wr_reg(ADDR_PORT3_DIR, 8'h00);
    rd_reg(ADDR_PORT3_DIR, d);
    `CHK(d, 8'h80)
    `CHK(pin_oe[31:24], 8'h7f)
    // the two-port build reads zero there and keeps ports 2, 3 inputs
    `CHK(rdata2, 8'h00)
    `CHK(pin_oe2, 32'h00003ca5)
    `CHK(pin_in2, 32'hffffc35a)
    // unmapped address reads zero and a write there changes nothing
    wr_reg(8'h97, 8'h00);
    rd_reg(8'h97, d);
    `CHK(d, 8'h00)
    rd_reg(ADDR_PORT2_DIR, d);
    `CHK(d, 8'hff)
    // reset option storage reads zero; output set of pin 5, port 0
    wr_reg(ADDR_PORT0_OPT, 8'h0d);
    rd_reg(ADDR_PORT0_OPT, d);
    `CHK(d, 8'h00)
    // one write per pin, both option sets, every index, four ports
    for (int p = 0; p < 4; p++) begin
      oa = ADDR_PORT0_OPT + 8'(p);
      for (int io = 0; io < 2; io++) begin
        for (int i = 0; i < 8; i++) begin
          wr_reg(oa, {opt_val(p, io, i), 1'(io), 1'b0, 3'(i)});
        end
      end
    end
    // capture with a nonzero option field must not disturb storage
    for (int p = 0; p < 4; p++) begin
      oa = ADDR_PORT0_OPT + 8'(p);
      for (int io = 0; io < 2; io++) begin
        for (int i = 0; i < 8; i++) begin
          wr_reg(oa, {3'h7, 1'(io), 1'b1, 3'(i)});
          rd_reg(oa, d);
          `CHK(d, {opt_val(p, io, i), 5'h00})
        end
      end
    end
    // low-frequency clock select codes, selected and unselected
    for (int k = 0; k < 5; k++) begin
      @(posedge mclk);
      lf_req <= codes[k];
      repeat (3) @(posedge mclk);
      #1;
      `CHK(xtal, codes[k] == 3'h0)
      `CHK(low_amp, codes[k] == 3'h3)
      `CHK(dig_clk, codes[k] == 3'h4)
    end
    // flash serial pins follow the program-mode pin only
    `CHK(flash_en, 1'b0)
    @(posedge mclk);
    program_mode_pin_req <= 1'b1;
    repeat (6) @(posedge mclk);
    #1;
    `CHK(flash_en, 1'b1)
    @(posedge mclk);
    program_mode_pin_req <= 1'b0;
    repeat (6) @(posedge mclk);
    #1;
    `CHK(flash_en, 1'b0)
    // a second reset restores directions and clears stored options
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    rd_reg(ADDR_PORT0_DIR, d);
    `CHK(d, 8'hff)
    `CHK(pin_oe, 32'h00000000)
    wr_reg(ADDR_PORT1_OPT, 8'h1a);
    rd_reg(ADDR_PORT1_OPT, d);
    `CHK(d, 8'h00)
    close_out();
  end
endmodule
